// File: hw/aewed_pkg.sv
// constants, field layouts and carrier types for the equation evaluator and its error detector
// assumes a single 20 MHz clock domain; every input comes from scan-program logic on that clock
package aewed_pkg;

  // operand, intermediate and block-reference widths
  localparam int OPND_W = 16;
  localparam int WIDE_W = 64;
  localparam int REF_W  = 4;

  typedef logic signed [OPND_W-1:0] aewed_word_t;
  typedef logic signed [WIDE_W-1:0] aewed_wide_t;

  // arithmetic sign codes
  localparam logic [1:0] SIGN_ADD = 2'h0;
  localparam logic [1:0] SIGN_SUB = 2'h1;
  localparam logic [1:0] SIGN_MUL = 2'h2;
  localparam logic [1:0] SIGN_DIV = 2'h3;

  // priority marks: round bracket beats square bracket beats none
  localparam logic [1:0] PRIO_NONE   = 2'h0;
  localparam logic [1:0] PRIO_SQUARE = 2'h1;
  localparam logic [1:0] PRIO_ROUND  = 2'h2;

  // error-select codes
  localparam logic [1:0] ERR_SEL_ZDIV = 2'h0;
  localparam logic [1:0] ERR_SEL_OVFL = 2'h1;
  localparam logic [1:0] ERR_SEL_ANY  = 2'h2;

  // block references: empty, and the number of this evaluator (arbitrary)
  localparam logic [REF_W-1:0] REF_EMPTY     = 4'h0;
  localparam logic [REF_W-1:0] EVAL_BLOCK_ID = 4'h1;

  // saturation limits and reset values
  localparam aewed_word_t RESULT_MAX = 16'sh7FFF;
  localparam aewed_word_t RESULT_MIN = 16'sh8000;
  localparam aewed_word_t RESULT_RST = 16'sh0000;
  localparam aewed_wide_t WIDE_MAX   = 64'sh0000_0000_0000_7FFF;
  localparam aewed_wide_t WIDE_MIN   = 64'shFFFF_FFFF_FFFF_8000;
  localparam aewed_wide_t WIDE_ZERO  = 64'sh0000_0000_0000_0000;
  localparam aewed_wide_t WIDE_ONE   = 64'sh0000_0000_0000_0001;
  localparam logic        FLAG_RST   = 1'b0;

  typedef struct packed {
    aewed_word_t firstOperandValue;
    aewed_word_t secondOperandValue;
    aewed_word_t thirdOperandValue;
    aewed_word_t fourthOperandValue;
  } aewed_operands_t;

  typedef struct packed {
    logic [1:0] sign;
    logic [1:0] prio;
  } aewed_oper_t;

  typedef struct packed {
    aewed_oper_t firstArithSign;
    aewed_oper_t secondArithSign;
    aewed_oper_t thirdArithSign;
  } aewed_opers_t;

  typedef struct packed {
    aewed_wide_t value;
    logic        zeroDiv;
  } aewed_step_t;

endpackage : aewed_pkg

// File: hw/aewed_top.sv
// four-operand equation evaluator with saturation, plus an error detector on its flags
// assumes all inputs are driven by scan-program logic on sys_clk; execStrobe marks one scan step
//
// Contract
// - evaluate four operands with three operators into one result
// - each operator slot is add, subtract, multiply or divide
// - round-bracket operators first, square next, unmarked last
// - result is rounded to the nearest integer
// - enable low: result zero under policy 0, held under policy 1
// - divide by zero and overflow set separate flags
// - each evaluation writes both flags as 1 or 0
// - divide by zero or positive overflow gives 32767, negative overflow -32768
// - evaluator is activated by a rising edge of its enable
// - detector is activated by a rising edge of its own enable
// - detector watches the one evaluator named by its block reference
// - detector output follows zero-divide, overflow or either, per select
// - self-clear: output cleared before each detector execution
// - no self-clear: output stays set until reset
// - detector reset clears the output; here a detector hit in the same cycle sets it instead
// - same-scan report if evaluator runs first, else next scan
// - empty block reference keeps detector output at 0
`timescale 1ns/1ns
`default_nettype none

module aewed_top (
  // clock and reset
  input  wire  logic                       sys_clk,
  input  wire  logic                       rst_n,
  // scan step
  input  wire  logic                       execStrobe,
  input  wire  logic                       evalFirst,
  // evaluator
  input  wire  logic                       evalEnable,
  input  wire  logic                       holdOnDisable,
  input  wire  aewed_pkg::aewed_operands_t operands,
  input  wire  aewed_pkg::aewed_opers_t    operators,
  output logic signed [15:0]               mathResult,
  output logic                             zeroDivideFlag,
  output logic                             overflowFlag,
  output logic                             evalDone,
  // error detector
  input  wire  logic                       detEnable,
  input  wire  logic                       detReset,
  input  wire  logic [1:0]                 errSelect,
  input  wire  logic                       selfClearSelect,
  input  wire  logic [3:0]                 sourceBlockRef,
  output logic                             errorOut
);
  import aewed_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic helpers

  function automatic aewed_step_t combine(input aewed_wide_t a, input aewed_wide_t b, input logic [1:0] sign);
    aewed_step_t res;
    aewed_wide_t q;
    aewed_wide_t r;
    aewed_wide_t absR;
    aewed_wide_t absB;
    res.value   = WIDE_ZERO;
    res.zeroDiv = 1'b0;
    q    = WIDE_ZERO;
    r    = WIDE_ZERO;
    absR = WIDE_ZERO;
    absB = WIDE_ZERO;
    unique case (sign)
      SIGN_ADD: res.value = a + b;
      SIGN_SUB: res.value = a - b;
      SIGN_MUL: res.value = a * b;
      SIGN_DIV: begin
        if (b == WIDE_ZERO) begin
          res.zeroDiv = 1'b1;
        end else begin
          q    = a / b;
          r    = a % b;
          absR = (r < WIDE_ZERO) ? -r : r;
          absB = (b < WIDE_ZERO) ? -b : b;
          // half away from zero
          if ((absR <<< 1) >= absB) begin
            q = ((a < WIDE_ZERO) != (b < WIDE_ZERO)) ? q - WIDE_ONE : q + WIDE_ONE;
          end
          res.value = q;
        end
      end
    endcase
    return res;
  endfunction : combine

  // reduce four values by bracket priority, leftmost first among equals
  function automatic aewed_step_t evaluate(input aewed_operands_t opnd, input aewed_opers_t opr);
    aewed_wide_t v [4];
    logic [1:0]  s [3];
    logic [1:0]  p [3];
    aewed_step_t st;
    aewed_step_t res;
    int          k;
    v[0] = aewed_wide_t'(opnd.firstOperandValue);
    v[1] = aewed_wide_t'(opnd.secondOperandValue);
    v[2] = aewed_wide_t'(opnd.thirdOperandValue);
    v[3] = aewed_wide_t'(opnd.fourthOperandValue);
    s[0] = opr.firstArithSign.sign;
    s[1] = opr.secondArithSign.sign;
    s[2] = opr.thirdArithSign.sign;
    p[0] = opr.firstArithSign.prio;
    p[1] = opr.secondArithSign.prio;
    p[2] = opr.thirdArithSign.prio;
    res.value   = WIDE_ZERO;
    res.zeroDiv = 1'b0;
    st          = res;
    k           = 0;
    for (int n = 3; n > 0; n--) begin
      k = 0;
      for (int i = 1; i < 3; i++) begin
        if (i < n && p[i] > p[k]) begin
          k = i;
        end
      end
      st          = combine(v[k], v[k+1], s[k]);
      res.zeroDiv = res.zeroDiv | st.zeroDiv;
      v[k]        = st.value;
      for (int j = 1; j < 3; j++) begin
        if (j > k && j < n) begin
          v[j] = v[j+1];
        end
      end
      for (int j = 0; j < 2; j++) begin
        if (j >= k && j < n - 1) begin
          s[j] = s[j+1];
          p[j] = p[j+1];
        end
      end
    end
    res.value = v[0];
    return res;
  endfunction : evaluate

  function automatic logic errPick(input logic [1:0] sel, input logic zd, input logic ovf);
    logic hit;
    hit = 1'b0;
    unique case (sel)
      ERR_SEL_ZDIV: hit = zd;
      ERR_SEL_OVFL: hit = ovf;
      ERR_SEL_ANY:  hit = zd | ovf;
      default:      hit = 1'b0;
    endcase
    return hit;
  endfunction : errPick

  ////////////////////////////////////////////////////////////////////////////
  // evaluator

  aewed_word_t result_q;
  aewed_word_t result_d;
  logic        zeroDiv_q;
  logic        zeroDiv_d;
  logic        ovfl_q;
  logic        ovfl_d;
  logic        evalDone_q;
  logic        evalEnPrev_q;
  logic        evalEnPrev_d;
  logic        evalArmed_q;
  logic        evalArmed_d;

  aewed_step_t evalNow;
  logic        zdNow;
  logic        ovHigh;
  logic        ovLow;
  logic        ovNow;
  aewed_word_t resultNow;
  logic        evalRun;
  logic        evalStep;

  assign evalNow   = evaluate(operands, operators);
  assign zdNow     = evalNow.zeroDiv;
  assign ovHigh    = !zdNow && (evalNow.value > WIDE_MAX);
  assign ovLow     = !zdNow && (evalNow.value < WIDE_MIN);
  assign ovNow     = ovHigh | ovLow;
  assign resultNow = (zdNow | ovHigh) ? RESULT_MAX :
                     ovLow ? RESULT_MIN : evalNow.value[OPND_W-1:0];

  // active once a rising edge of enable has been seen at a scan step
  assign evalRun      = evalEnable && (evalArmed_q || !evalEnPrev_q);
  assign evalStep     = execStrobe && evalRun;
  assign evalEnPrev_d = execStrobe ? evalEnable : evalEnPrev_q;
  assign evalArmed_d  = execStrobe ? evalRun : evalArmed_q;
  assign zeroDiv_d    = evalStep ? zdNow : zeroDiv_q;
  assign ovfl_d       = evalStep ? ovNow : ovfl_q;
  assign result_d     = !execStrobe ? result_q :
                        evalRun ? resultNow :
                        holdOnDisable ? result_q : RESULT_RST;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_q     <= RESULT_RST;
      zeroDiv_q    <= FLAG_RST;
      ovfl_q       <= FLAG_RST;
      evalDone_q   <= FLAG_RST;
      evalEnPrev_q <= FLAG_RST;
      evalArmed_q  <= FLAG_RST;
    end else begin
      result_q     <= result_d;
      zeroDiv_q    <= zeroDiv_d;
      ovfl_q       <= ovfl_d;
      evalDone_q   <= evalStep;
      evalEnPrev_q <= evalEnPrev_d;
      evalArmed_q  <= evalArmed_d;
    end
  end

  assign mathResult     = result_q;
  assign zeroDivideFlag = zeroDiv_q;
  assign overflowFlag   = ovfl_q;
  assign evalDone       = evalDone_q;

  ////////////////////////////////////////////////////////////////////////////
  // error detector

  logic errorOut_q;
  logic errorOut_d;
  logic detEnPrev_q;
  logic detEnPrev_d;
  logic detArmed_q;
  logic detArmed_d;
  logic detRun;
  logic detStep;
  logic refValid;
  logic seenZd;
  logic seenOv;
  logic detHit;
  logic errorKeep;

  assign detRun      = detEnable && (detArmed_q || !detEnPrev_q);
  assign detStep     = execStrobe && detRun;
  assign detEnPrev_d = execStrobe ? detEnable : detEnPrev_q;
  assign detArmed_d  = execStrobe ? detRun : detArmed_q;
  assign refValid    = (sourceBlockRef != REF_EMPTY) && (sourceBlockRef == EVAL_BLOCK_ID);
  // evaluator first in the scan: see this step's flags, else last step's
  assign seenZd      = (evalStep && evalFirst) ? zdNow : zeroDiv_q;
  assign seenOv      = (evalStep && evalFirst) ? ovNow : ovfl_q;
  assign detHit      = detStep && errPick(errSelect, seenZd, seenOv);
  assign errorKeep   = detReset ? 1'b0 :
                       (detStep && selfClearSelect) ? 1'b0 :
                       errorOut_q;
  assign errorOut_d  = refValid && (errorKeep || detHit);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      errorOut_q  <= FLAG_RST;
      detEnPrev_q <= FLAG_RST;
      detArmed_q  <= FLAG_RST;
    end else begin
      errorOut_q  <= errorOut_d;
      detEnPrev_q <= detEnPrev_d;
      detArmed_q  <= detArmed_d;
    end
  end

  assign errorOut = errorOut_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  a_result_zeroed: assert property (@(posedge sys_clk) disable iff (!rst_n)
    execStrobe && !evalEnable && !holdOnDisable |=> mathResult == RESULT_RST)
    else $error("result not zeroed while disabled");

  a_result_held: assert property (@(posedge sys_clk) disable iff (!rst_n)
    execStrobe && !evalEnable && holdOnDisable |=> $stable(mathResult))
    else $error("result not held while disabled");

  a_zdiv_saturate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    evalStep && zdNow |=> mathResult == RESULT_MAX && zeroDivideFlag && !overflowFlag)
    else $error("divide by zero not saturated high");

  a_neg_saturate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    evalStep && ovLow |=> mathResult == RESULT_MIN && overflowFlag && !zeroDivideFlag)
    else $error("negative overflow not saturated low");

  a_flags_written: assert property (@(posedge sys_clk) disable iff (!rst_n)
    evalStep |=> zeroDivideFlag == $past(zdNow) && overflowFlag == $past(ovNow))
    else $error("flags not written by evaluation");

  a_rise_activates: assert property (@(posedge sys_clk) disable iff (!rst_n)
    execStrobe && evalEnable && !evalEnPrev_q |=> evalDone)
    else $error("rising enable did not start evaluation");

  a_done_marks: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !execStrobe |=> !evalDone && $stable(mathResult))
    else $error("result moved without execute strobe");

  a_empty_ref: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sourceBlockRef == REF_EMPTY |=> !errorOut)
    else $error("detector set with empty reference");

  a_latch_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
    errorOut && !selfClearSelect && !detReset && refValid |=> errorOut)
    else $error("latched error dropped without reset");

  a_reset_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
    detReset && !detHit |=> !errorOut)
    else $error("detector reset did not clear output");

  a_self_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    detStep && selfClearSelect && refValid |=> errorOut == $past(detHit))
    else $error("self-clear output not latest result");

  a_same_scan: assert property (@(posedge sys_clk) disable iff (!rst_n)
    detStep && evalStep && evalFirst && refValid && errSelect == ERR_SEL_ANY && (zdNow || ovNow)
    |=> errorOut && (zeroDivideFlag || overflowFlag))
    else $error("error not reported in same scan");

endmodule : aewed_top

`default_nettype wire

// File: bench/aewed_scan_partner.sv
// scan-program model: hands operands and operators to the evaluator with a one-cycle execute strobe
// assumes the bench raises stepReq just after a rising edge, at most one request every two cycles
`timescale 1ns/1ns
`default_nettype none

module aewed_scan_partner (
  // clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  // requests from the bench
  input  wire logic                       stepReq,
  input  wire logic                       padTail,
  input  wire aewed_pkg::aewed_operands_t reqOperands,
  input  wire aewed_pkg::aewed_opers_t    reqOperators,
  // towards the evaluator
  output var  logic                       execStrobe,
  output var  aewed_pkg::aewed_operands_t operands,
  output var  aewed_pkg::aewed_opers_t    operators
);
  import aewed_pkg::*;

  localparam aewed_oper_t PLUS_ZERO = {SIGN_ADD, PRIO_NONE};

  //////////////////////////////////////////////////////////////////////////////
  // one strobe per request; short equations padded with plus zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      execStrobe <= 1'b0;
      operands   <= '0;
      operators  <= '0;
    end else begin
      execStrobe <= stepReq;
      operands   <= reqOperands;
      operators  <= reqOperators;
      if (padTail) begin
        operands.thirdOperandValue  <= RESULT_RST;
        operands.fourthOperandValue <= RESULT_RST;
        operators.secondArithSign   <= PLUS_ZERO;
        operators.thirdArithSign    <= PLUS_ZERO;
      end
    end
  end

endmodule : aewed_scan_partner

`default_nettype wire

// File: bench/aewed_top_tb_top.sv
// self-checking bench for the equation evaluator and its error detector
// assumes the scan partner model drives operands, operators and the execute strobe
`timescale 1ns/1ns
`default_nettype none

module aewed_top_tb_top;
  import aewed_pkg::*;

  logic            sys_clk = 1'b0;
  logic            rst_n, execStrobe, evalFirst, evalEnable, holdOnDisable, stepReq, padTail;
  logic            detEnable, detReset, selfClearSelect, zeroDivideFlag, overflowFlag, evalDone, errorOut;
  logic [1:0]      errSelect;
  logic [3:0]      sourceBlockRef;
  logic [15:0]     mathResult;
  aewed_operands_t operands, reqOperands;
  aewed_opers_t    operators, reqOperators;
  int              n_mismatch = 0;
  int              tests_run = 0;

  always #25 sys_clk = ~sys_clk;

  aewed_scan_partner partner (.sys_clk(sys_clk), .rst_n(rst_n), .stepReq(stepReq), .padTail(padTail),
    .reqOperands(reqOperands), .reqOperators(reqOperators), .execStrobe(execStrobe),
    .operands(operands), .operators(operators));

  aewed_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .execStrobe(execStrobe), .evalFirst(evalFirst),
    .evalEnable(evalEnable), .holdOnDisable(holdOnDisable), .operands(operands), .operators(operators),
    .mathResult(mathResult), .zeroDivideFlag(zeroDivideFlag), .overflowFlag(overflowFlag),
    .evalDone(evalDone), .detEnable(detEnable), .detReset(detReset), .errSelect(errSelect),
    .selfClearSelect(selfClearSelect), .sourceBlockRef(sourceBlockRef), .errorOut(errorOut));

  //////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic aewed_oper_t op(input logic [1:0] s, input logic [1:0] p);
    return {s, p};
  endfunction : op

  function automatic logic [15:0] st();
    return {13'h0000, evalDone, zeroDivideFlag, overflowFlag};
  endfunction : st

  task automatic scan(input aewed_operands_t o, input aewed_opers_t p, input logic pad);
    reqOperands  = o;
    reqOperators = p;
    padTail      = pad;
    stepReq      = 1'b1;
    @(posedge sys_clk);
    #2 stepReq = 1'b0;
    @(posedge sys_clk);
    #2;
  endtask : scan

  // two-operand equation; the partner pads the tail, so the junk tail must not matter
  task automatic scan2(input logic [15:0] a, input logic [15:0] b, input logic [1:0] s);
    scan({a, b, 16'h5555, 16'h5555}, {op(s, PRIO_NONE), op(SIGN_MUL, PRIO_ROUND), op(SIGN_DIV, PRIO_ROUND)}, 1'b1);
  endtask : scan2

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  //////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_examples();
    scan({16'h000C, 16'h0006, 16'h0003, 16'h0001},
         {op(SIGN_ADD, PRIO_SQUARE), op(SIGN_DIV, PRIO_ROUND), op(SIGN_SUB, PRIO_NONE)}, 1'b0);
    chk(mathResult, 16'h000D);
    chk(st(), 16'h0004);
    scan({16'h0002, 16'h0003, 16'h0001, 16'h0004},
         {op(SIGN_ADD, PRIO_NONE), op(SIGN_MUL, PRIO_SQUARE), op(SIGN_ADD, PRIO_ROUND)}, 1'b0);
    chk(mathResult, 16'h0011);
    scan({16'h0064, 16'h0019, 16'h0002, 16'h0001},
         {op(SIGN_SUB, PRIO_ROUND), op(SIGN_DIV, PRIO_NONE), op(SIGN_ADD, PRIO_SQUARE)}, 1'b0);
    chk(mathResult, 16'h0019);
    chk(st(), 16'h0004);
    @(posedge sys_clk);
    #2 chk(st(), 16'h0000);
    $display("test examples done");
  endtask : t_examples

  task automatic t_signs();
    logic [1:0]  sg [4] = '{SIGN_ADD, SIGN_SUB, SIGN_MUL, SIGN_DIV};
    logic [15:0] ex [4] = '{16'h0009, 16'h0005, 16'h000E, 16'h0004};
    for (int i = 0; i < 4; i++) begin
      scan2(16'h0007, 16'h0002, sg[i]);
      chk(mathResult, ex[i]);
    end
    scan2(16'hFFF9, 16'h0002, SIGN_DIV);
    chk(mathResult, 16'hFFFC);
    $display("test signs done");
  endtask : t_signs

  task automatic t_errors();
    logic [15:0] a [4]  = '{16'h0005, 16'h00C8, 16'hFF38, 16'h0007};
    logic [15:0] b [4]  = '{16'h0000, 16'h00C8, 16'h00C8, 16'h0002};
    logic [1:0]  sg [4] = '{SIGN_DIV, SIGN_MUL, SIGN_MUL, SIGN_SUB};
    logic [15:0] er [4] = '{16'h7FFF, 16'h7FFF, 16'h8000, 16'h0005};
    logic [15:0] es [4] = '{16'h0006, 16'h0005, 16'h0005, 16'h0004};
    for (int i = 0; i < 4; i++) begin
      scan2(a[i], b[i], sg[i]);
      chk(mathResult, er[i]);
      chk(st(), es[i]);
    end
    $display("test errors done");
  endtask : t_errors

  task automatic t_detect();
    selfClearSelect = 1'b1;
    errSelect       = 2'h3;
    scan2(16'h0005, 16'h0000, SIGN_DIV);
    chk({15'h0000, errorOut}, 16'h0000);
    for (int s = 0; s < 3; s++) begin
      for (int e = 0; e < 2; e++) begin
        errSelect = 2'(s);
        if (e == 0) begin
          scan2(16'h0005, 16'h0000, SIGN_DIV);
        end else begin
          scan2(16'h00C8, 16'h00C8, SIGN_MUL);
        end
        chk({15'h0000, errorOut}, {15'h0000, (s == 2) || (s == e)});
      end
    end
    evalFirst = 1'b0;
    scan2(16'h0007, 16'h0002, SIGN_SUB);
    chk({15'h0000, errorOut}, 16'h0001);
    scan2(16'h0005, 16'h0000, SIGN_DIV);
    chk({15'h0000, errorOut}, 16'h0000);
    scan2(16'h0007, 16'h0002, SIGN_SUB);
    chk({15'h0000, errorOut}, 16'h0001);
    evalFirst = 1'b1;
    scan2(16'h0005, 16'h0000, SIGN_DIV);
    detEnable = 1'b0;
    scan2(16'h0007, 16'h0002, SIGN_SUB);
    chk({15'h0000, errorOut}, 16'h0001);
    detEnable = 1'b1;
    scan2(16'h0007, 16'h0002, SIGN_SUB);
    chk({15'h0000, errorOut}, 16'h0000);
    $display("test detect done");
  endtask : t_detect

  task automatic t_latch();
    selfClearSelect = 1'b0;
    errSelect       = ERR_SEL_ZDIV;
    scan2(16'h0005, 16'h0000, SIGN_DIV);
    scan2(16'h0007, 16'h0002, SIGN_SUB);
    chk({15'h0000, errorOut}, 16'h0001);
    detReset = 1'b1;
    @(posedge sys_clk);
    #2 detReset = 1'b0;
    chk({15'h0000, errorOut}, 16'h0000);
    sourceBlockRef = REF_EMPTY;
    scan2(16'h0005, 16'h0000, SIGN_DIV);
    chk({15'h0000, errorOut}, 16'h0000);
    chk(st(), 16'h0006);
    sourceBlockRef = 4'h2;
    scan2(16'h0005, 16'h0000, SIGN_DIV);
    chk({15'h0000, errorOut}, 16'h0000);
    sourceBlockRef = EVAL_BLOCK_ID;
    $display("test latch done");
  endtask : t_latch

  task automatic t_enable();
    holdOnDisable = 1'b0;
    evalEnable    = 1'b0;
    scan2(16'h0005, 16'h0000, SIGN_DIV);
    chk(mathResult, 16'h0000);
    chk(st(), 16'h0002);
    holdOnDisable = 1'b1;
    evalEnable    = 1'b1;
    scan2(16'h0007, 16'h0002, SIGN_SUB);
    chk(mathResult, 16'h0005);
    chk(st(), 16'h0004);
    evalEnable = 1'b0;
    scan2(16'h0005, 16'h0000, SIGN_DIV);
    chk(mathResult, 16'h0005);
    chk(st(), 16'h0000);
    evalEnable = 1'b1;
    $display("test enable done");
  endtask : t_enable

  //////////////////////////////////////////////////////////////////////////////
  // main sequence and hang guard
  initial begin
    {rst_n, stepReq, padTail, detReset, holdOnDisable} = '0;
    {evalFirst, evalEnable, detEnable, selfClearSelect} = 4'hF;
    errSelect      = ERR_SEL_ANY;
    sourceBlockRef = EVAL_BLOCK_ID;
    reqOperands    = '0;
    reqOperators   = '0;
    repeat (16) @(posedge sys_clk);
    #2 rst_n = 1'b1;
    chk(st(), 16'h0000);
    chk({mathResult[14:0], errorOut}, 16'h0000);
    t_examples();
    t_signs();
    t_errors();
    t_detect();
    t_latch();
    t_enable();
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    report_and_stop();
  end

endmodule : aewed_top_tb_top

`default_nettype wire
